//--- hw/sgti_pkg.sv
/*
  Constants for the spray gun trigger interlock block.
  Assumes a 200 MHz system clock.
*/
package sgti_pkg;
  // ==========================================================
  // Timing
  localparam longint unsigned CLK_HZ = 64'd200_000_000;
  localparam int LAMP_TEST_S = 3;
  localparam int REV_SHOW_S = 1;
  localparam longint unsigned LAMP_TEST_CYC = CLK_HZ * LAMP_TEST_S;
  localparam longint unsigned REV_SHOW_CYC = CLK_HZ * REV_SHOW_S;
  localparam int FLASH_HALF_CYC = 20_000_000;
  // ==========================================================
  // Settings
  localparam logic [6:0] KV_MIN = 7'h19;
  localparam logic [6:0] KV_MAX = 7'h64;
  localparam logic [6:0] KV_RST = 7'h3F;
  localparam logic TRIG_TYPE_RST = 1'b0;
  localparam logic TRIG_EXTERNAL = 1'b0;
  localparam logic TRIG_CONTINUOUS = 1'b1;
  // ==========================================================
  // Display modes
  typedef enum logic [2:0] {
    SGTI_DSP_LAMP, SGTI_DSP_CONFIG, SGTI_DSP_SWREV, SGTI_DSP_HWREV, SGTI_DSP_RUN
  } sgti_disp_e;
endpackage : sgti_pkg

//--- hw/sgti_sync_if.sv
/*
  Interface carrying synchronised field inputs and trigger edges into the interlock logic.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface sgti_sync_if;
  logic trigger;
  logic lockIn;
  logic chamberClosed;
  logic trigRise;
  logic trigFall;
  modport src (output trigger, lockIn, chamberClosed, trigRise, trigFall);
  modport dst (input trigger, lockIn, chamberClosed, trigRise, trigFall);
endinterface : sgti_sync_if

//--- hw/sgti_in_sync.sv
/*
  Three-stage synchronisers and trigger edge detection.
  Assumes asynchronous field inputs and one system clock.
*/
`timescale 1ns/1ps
module sgti_in_sync (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic trigIn,
  input wire logic lockIn,
  input wire logic chamberIn,
  sgti_sync_if.src out
);
  // ==========================================================
  // Synchronisers
  logic [2:0] s1_r, s2_r, s3_r, s1_nxt, s2_nxt, s3_nxt, val_r, val_nxt;
  logic rise_r, fall_r, rise_nxt, fall_nxt;
  always_comb begin
    s1_nxt = {chamberIn, lockIn, trigIn};
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    val_nxt = val_r;
    // Change accepted only once the second and third stages agree [R18]
    for (int i = 0; i < 3; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        val_nxt[i] = s3_r[i];
      end
    end
    rise_nxt = val_nxt[0] & ~val_r[0];
    fall_nxt = ~val_nxt[0] & val_r[0];
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      s3_r <= 3'h0;
      val_r <= 3'h0; // Edge detector cleared at reset [R18]
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      val_r <= val_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end
  assign out.trigger = val_r[0];
  assign out.lockIn = val_r[1];
  assign out.chamberClosed = val_r[2];
  assign out.trigRise = rise_r;
  assign out.trigFall = fall_r;
  edge_excl_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(rise_r && fall_r)) else $error("rise and fall together"); // [R18]
endmodule : sgti_in_sync

//--- hw/spray_gun_trigger_interlock.sv
/*
  Gun enable and interlock logic of a spray coating controller.
  Assumes one 200 MHz clock, synchronous reset and that saved
  settings are presented on restore ports from non-volatile storage.
*/
// Behaviour
// R01 - Lamp test: all lit three seconds
// R02 - Then show auto or manual configuration
// R03 - Software then hardware revision, one second each
// R04 - Restore saved settings after boot
// R05 - Spray only with trigger, closed, unlocked
// R06 - Trigger blocked: system off, LED flashes
// R07 - No trigger: system off, LED dark
// R08 - Short circuit flashes voltage display
// R09 - Gun follows production trigger automatically
// R10 - Local key may switch triggered gun off
// R11 - Re-arm needs trigger fall then rise; a second key press also re-arms here
// R12 - Closing chamber does not re-arm gun
// R13 - Trigger type: 0 external, 1 continuous
// R14 - Lock blocks triggering, cuts voltage, air
// R15 - Lock shows lock indication text
// R16 - Operator should leave key at activate
// R17 - Voltage setpoint clamped 25 to 100 kV; zero is kept as a no-charge setting
// R18 - Inputs synchronised, edge detector reset
`timescale 1ns/1ps
module spray_gun_trigger_interlock #(
  parameter longint unsigned LAMP_CYC = sgti_pkg::LAMP_TEST_CYC,
  parameter longint unsigned REV_CYC = sgti_pkg::REV_SHOW_CYC,
  parameter int FLASH_CYC = sgti_pkg::FLASH_HALF_CYC,
  parameter logic [9:0] SW_REV = 10'h064,
  parameter logic [9:0] HW_REV = 10'h065
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic trigIn,
  input wire logic lockIn,
  input wire logic chamberIn,
  input wire logic keyPress,
  input wire logic autoGunCfg,
  input wire logic shortCircuit,
  input wire logic restoreValid,
  input wire logic restoreTrigType,
  input wire logic [6:0] restoreKv,
  input wire logic setTrigType,
  input wire logic setTrigTypeStb,
  input wire logic [6:0] setKv,
  input wire logic setKvStb,
  output logic lampTest,
  output logic [2:0] dispMode,
  output logic [9:0] dispValue,
  output logic configAuto,
  output logic bootDone,
  output logic hvEnable,
  output logic airEnable,
  output logic spraying,
  output logic trigLed,
  output logic kvDispFlash,
  output logic kvDispOff,
  output logic lockText,
  output logic trigType,
  output logic [6:0] kvSetpoint
);
  // Counters are 32 bits wide; the lamp test must last two cycles at least
  if (LAMP_CYC < 2 || REV_CYC < 1 || FLASH_CYC < 1 ||
      LAMP_CYC > 64'hFFFF_FFFF || REV_CYC > 64'hFFFF_FFFF) begin : g_bad_timing
    $error("timing counts out of range");
  end
  sgti_sync_if syn();
  sgti_in_sync u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .trigIn(trigIn),
    .lockIn(lockIn),
    .chamberIn(chamberIn),
    .out(syn.src)
  );
  // ==========================================================
  // Boot display sequence
  sgti_pkg::sgti_disp_e disp_r, disp_nxt;
  logic [31:0] bootCnt_r, bootCnt_nxt;
  logic [31:0] bootLimit;
  logic cfgAuto_r, cfgAuto_nxt;
  always_comb begin
    disp_nxt = disp_r;
    bootCnt_nxt = bootCnt_r + 32'h1;
    cfgAuto_nxt = cfgAuto_r;
    bootLimit = 32'(REV_CYC);
    case (disp_r)
      sgti_pkg::SGTI_DSP_LAMP: begin
        bootLimit = 32'(LAMP_CYC); // [R01]
        cfgAuto_nxt = autoGunCfg;
      end
      default: begin
      end
    endcase
    if (disp_r != sgti_pkg::SGTI_DSP_RUN && bootCnt_r >= bootLimit - 32'h1) begin
      bootCnt_nxt = 32'h0;
      case (disp_r)
        sgti_pkg::SGTI_DSP_LAMP: disp_nxt = sgti_pkg::SGTI_DSP_CONFIG; // [R02]
        sgti_pkg::SGTI_DSP_CONFIG: disp_nxt = sgti_pkg::SGTI_DSP_SWREV; // [R03]
        sgti_pkg::SGTI_DSP_SWREV: disp_nxt = sgti_pkg::SGTI_DSP_HWREV; // [R03]
        default: disp_nxt = sgti_pkg::SGTI_DSP_RUN;
      endcase
    end
    if (disp_r == sgti_pkg::SGTI_DSP_RUN) begin
      bootCnt_nxt = 32'h0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      disp_r <= sgti_pkg::SGTI_DSP_LAMP;
      bootCnt_r <= 32'h0;
      cfgAuto_r <= 1'b0;
    end else begin
      disp_r <= disp_nxt;
      bootCnt_r <= bootCnt_nxt;
      cfgAuto_r <= cfgAuto_nxt;
    end
  end
  wire running = (disp_r == sgti_pkg::SGTI_DSP_RUN);
  // ==========================================================
  // Settings, restored once boot completes
  logic trigType_r, trigType_nxt, restored_r, restored_nxt;
  logic [6:0] kv_r, kv_nxt;
  function automatic logic [6:0] clampKv(input logic [6:0] v);
    if (v == 7'h00) begin
      return 7'h00; // Zero is a legal "no charge" setting
    end else if (v < sgti_pkg::KV_MIN) begin
      return sgti_pkg::KV_MIN;
    end else if (v > sgti_pkg::KV_MAX) begin
      return sgti_pkg::KV_MAX;
    end
    return v;
  endfunction : clampKv
  always_comb begin
    trigType_nxt = trigType_r;
    kv_nxt = kv_r;
    restored_nxt = restored_r;
    if (running && !restored_r && restoreValid) begin
      trigType_nxt = restoreTrigType; // [R04]
      kv_nxt = clampKv(restoreKv); // [R04] [R17]
      restored_nxt = 1'b1;
    end else if (running && restored_r) begin
      if (setTrigTypeStb) begin
        trigType_nxt = setTrigType; // [R13]
      end
      if (setKvStb) begin
        kv_nxt = clampKv(setKv); // [R17]
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trigType_r <= sgti_pkg::TRIG_TYPE_RST; // [R13]
      kv_r <= sgti_pkg::KV_RST;
      restored_r <= 1'b0;
    end else begin
      trigType_r <= trigType_nxt;
      kv_r <= kv_nxt;
      restored_r <= restored_nxt;
    end
  end
  // ==========================================================
  // Gun arming and interlock
  // The key toggles the local enable; after a local switch-off, a second key press or a
  // trigger fall then rise re-arms, so closing the chamber never restarts.
  logic localOff_r, localOff_nxt, sawFall_r, sawFall_nxt;
  logic [31:0] flashCnt_r, flashCnt_nxt;
  logic flash_r, flash_nxt;
  logic gunOn, blocked;
  always_comb begin
    localOff_nxt = localOff_r;
    sawFall_nxt = sawFall_r;
    if (keyPress && running) begin
      localOff_nxt = ~localOff_r; // [R10]
      // A fall in the switch-off cycle still counts, so the set wins
      sawFall_nxt = ~localOff_r & syn.trigFall; // [R11]
    end else if (localOff_r && syn.trigFall) begin
      sawFall_nxt = 1'b1; // [R11]
    end else if (localOff_r && sawFall_r && syn.trigRise) begin
      localOff_nxt = 1'b0; // [R11] [R12]
      sawFall_nxt = 1'b0;
    end
    flashCnt_nxt = flashCnt_r + 32'h1;
    flash_nxt = flash_r;
    if (flashCnt_r >= 32'(FLASH_CYC) - 32'h1) begin
      flashCnt_nxt = 32'h0;
      flash_nxt = ~flash_r;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      localOff_r <= 1'b0;
      sawFall_r <= 1'b0;
      flashCnt_r <= 32'h0;
      flash_r <= 1'b0;
    end else begin
      localOff_r <= localOff_nxt;
      sawFall_r <= sawFall_nxt;
      flashCnt_r <= flashCnt_nxt;
      flash_r <= flash_nxt;
    end
  end
  wire trigSrc = (trigType_r == sgti_pkg::TRIG_CONTINUOUS) ? 1'b1 : syn.trigger; // [R13] [R09]
  assign blocked = syn.lockIn || !syn.chamberClosed || localOff_r; // [R14]
  assign gunOn = running && trigSrc && !blocked; // [R05]
  // ==========================================================
  // Output registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lampTest <= 1'b1;
      dispMode <= 3'h0;
      dispValue <= 10'h000;
      configAuto <= 1'b0;
      bootDone <= 1'b0;
      hvEnable <= 1'b0;
      airEnable <= 1'b0;
      spraying <= 1'b0;
      trigLed <= 1'b0;
      kvDispFlash <= 1'b0;
      kvDispOff <= 1'b0;
      lockText <= 1'b0;
      trigType <= sgti_pkg::TRIG_TYPE_RST;
      kvSetpoint <= sgti_pkg::KV_RST;
    end else begin
      lampTest <= (disp_nxt == sgti_pkg::SGTI_DSP_LAMP); // [R01]
      dispMode <= disp_nxt;
      dispValue <= (disp_nxt == sgti_pkg::SGTI_DSP_SWREV) ? SW_REV :
                   (disp_nxt == sgti_pkg::SGTI_DSP_HWREV) ? HW_REV :
                   {3'h0, kv_r}; // [R03]
      configAuto <= cfgAuto_nxt; // [R02]
      bootDone <= running && restored_r; // [R04]
      hvEnable <= gunOn; // [R09] [R14]
      airEnable <= gunOn; // [R14]
      spraying <= gunOn; // [R05]
      // Steady on while spraying, flashing when blocked, dark without trigger
      trigLed <= gunOn ? 1'b1 : (running && trigSrc) ? flash_r : 1'b0; // [R06] [R07]
      kvDispFlash <= shortCircuit && running; // [R08]
      kvDispOff <= localOff_r && running;
      lockText <= syn.lockIn && running; // [R15]
      trigType <= trigType_r;
      kvSetpoint <= kv_r;
    end
  end
  // ==========================================================
  // Checks
  sequence lockSeen;
    syn.lockIn;
  endsequence
  lock_cuts_hv_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    lockSeen |=> !hvEnable && !airEnable) else $error("lock did not cut HV"); // [R14]
  lock_text_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    running && syn.lockIn |=> lockText) else $error("lock text missing"); // [R15]
  spray_cond_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    spraying |-> $past(syn.chamberClosed) && !$past(syn.lockIn)) else $error("bad spray"); // [R05]
  no_trig_dark_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !trigSrc |=> !trigLed && !spraying) else $error("LED lit without trigger"); // [R07]
  kv_range_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    kvSetpoint == 7'h00 || (kvSetpoint >= 7'h19 && kvSetpoint <= 7'h64))
    else $error("kV out of range"); // [R17]
  rearm_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    localOff_r && !localOff_nxt && !keyPress |-> sawFall_r && syn.trigRise)
    else $error("re-armed without toggle"); // [R11]
  short_flash_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    running && shortCircuit |=> kvDispFlash) else $error("no short flash"); // [R08]
  lamp_first_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> lampTest [*2]) else $error("lamp test absent"); // [R01]
  rev_order_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    disp_r == sgti_pkg::SGTI_DSP_HWREV |-> $past(disp_r) != sgti_pkg::SGTI_DSP_CONFIG)
    else $error("revision order"); // [R03]
  cfg_after_lamp_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    disp_r == sgti_pkg::SGTI_DSP_LAMP ##1 disp_r != sgti_pkg::SGTI_DSP_LAMP
    |-> disp_r == sgti_pkg::SGTI_DSP_CONFIG) else $error("config skipped"); // [R02]
  key_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    localOff_r |=> !spraying) else $error("spraying after key off"); // [R10]
endmodule : spray_gun_trigger_interlock

//--- test/sgti_parent_model.sv
/*
  Parent production machine model: drives the trigger and remote lock levels.
  Assumes callers change levels just after a rising edge of sys_clk.
*/
`timescale 1ns/1ps
module sgti_parent_model (
  input wire logic sys_clk,
  output logic trigOut,
  output logic lockOut
);
  // ==========================================================
  // Levels
  initial begin
    trigOut = 1'b0;
    lockOut = 1'b0;
  end
  // Production start and stop switch the trigger level
  task automatic run(input logic on);
    trigOut = on;
  endtask : run
  // Remote lock during cleaning
  task automatic lock(input logic on);
    lockOut = on;
  endtask : lock
  // Restart after a local stop: fall, long enough to pass the sync, then rise
  task automatic toggle();
    trigOut = 1'b0;
    repeat (12) @(posedge sys_clk);
    #1;
    trigOut = 1'b1;
  endtask : toggle
endmodule : sgti_parent_model

//--- test/spray_gun_trigger_interlock_tb_top.sv
/*
  Self-checking bench for the interlock top with a noted-result queue.
  Assumes shortened boot counts and the parent machine model.
*/
`timescale 1ns/1ps
module spray_gun_trigger_interlock_tb_top;
  // ==========================================================
  // Signals
  typedef struct packed {logic kind; logic [16:0] val; logic [16:0] msk;} sgti_note_s;
  localparam int LC = 20;
  logic sys_clk = 1'b0;
  logic rst_n, chamberIn, keyPress, autoGunCfg, shortCircuit, restoreValid, restoreTrigType;
  logic setTrigType, setTrigTypeStb, setKvStb, chk, clr;
  logic [6:0] restoreKv, setKv, expKv;
  logic trigIn, lockIn, lampTest, configAuto, bootDone, hvEnable, airEnable, spraying, trigLed;
  logic kvDispFlash, kvDispOff, lockText, trigType;
  logic [2:0] dispMode;
  logic [9:0] dispValue;
  logic [6:0] kvSetpoint;
  int n_errors = 0, checked = 0, ledCnt = 0, kvCnt = 0, seed = 32'hDFEE5D53;
  sgti_note_s q[$];
  initial forever #2.5 sys_clk = ~sys_clk;
  sgti_parent_model PARENT (.sys_clk(sys_clk), .trigOut(trigIn), .lockOut(lockIn));
  spray_gun_trigger_interlock #(.LAMP_CYC(LC), .REV_CYC(LC), .FLASH_CYC(4),
    .SW_REV(10'h064), .HW_REV(10'h065)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
    .trigIn(trigIn), .lockIn(lockIn), .chamberIn(chamberIn), .keyPress(keyPress),
    .autoGunCfg(autoGunCfg), .shortCircuit(shortCircuit), .restoreValid(restoreValid),
    .restoreTrigType(restoreTrigType), .restoreKv(restoreKv), .setTrigType(setTrigType),
    .setTrigTypeStb(setTrigTypeStb), .setKv(setKv), .setKvStb(setKvStb),
    .lampTest(lampTest), .dispMode(dispMode), .dispValue(dispValue),
    .configAuto(configAuto), .bootDone(bootDone), .hvEnable(hvEnable),
    .airEnable(airEnable), .spraying(spraying), .trigLed(trigLed),
    .kvDispFlash(kvDispFlash), .kvDispOff(kvDispOff), .lockText(lockText),
    .trigType(trigType), .kvSetpoint(kvSetpoint));
  // ==========================================================
  // Observer
  // Counting highs over a window tells dark, flashing and steady apart
  always @(posedge sys_clk) begin
    ledCnt <= clr ? 0 : ledCnt + int'(trigLed === 1'b1);
    kvCnt <= clr ? 0 : kvCnt + int'(kvDispFlash === 1'b1);
  end
  function automatic logic [1:0] cls(input int c);
    return (c == 0) ? 2'h0 : (c > 35) ? 2'h2 : 2'h1;
  endfunction : cls
  always @(posedge sys_clk) begin
    if (chk) begin : obs
      sgti_note_s n;
      logic [16:0] got;
      n = q.pop_front();
      got = n.kind ? {lampTest, dispMode, configAuto, dispValue, 2'h0} : {cls(ledCnt),
        cls(kvCnt), spraying, hvEnable, airEnable, lockText, kvDispOff, trigType, kvSetpoint};
      checked++;
      if ((got & n.msk) !== (n.val & n.msk)) begin
        n_errors++;
        $display("Error at %0t: got %0h expected %0h", $time, got & n.msk, n.val & n.msk);
      end
    end
  end
  // ==========================================================
  // Driver
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic note(input logic k, input logic [16:0] v, input logic [16:0] m);
    q.push_back('{k, v, m});
    chk = 1'b1;
    cyc(1);
    chk = 1'b0;
  endtask : note
  // Settle past the sync latency, then watch a 40-cycle window
  task automatic look(input logic [9:0] e);
    cyc(10);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(40);
    note(1'b0, {e, expKv}, 17'h1FFFF);
  endtask : look
  // One-cycle strobe: 0 key, 1 kV write, 2 trigger type write
  task automatic pulse(input int w);
    keyPress = (w == 0);
    setKvStb = (w == 1);
    setTrigTypeStb = (w == 2);
    cyc(1);
    {keyPress, setKvStb, setTrigTypeStb} = 3'h0;
  endtask : pulse
  task automatic stop_test();
    if (n_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  initial begin : main
    int v;
    logic [6:0] kvIn [8];
    kvIn = '{7'h00, 7'h0A, 7'h18, 7'h19, 7'h40, 7'h64, 7'h65, 7'h7F};
    kvIn[4] = 7'($random(seed));
    autoGunCfg = 1'($random(seed));
    restoreTrigType = 1'($random(seed));
    {rst_n, chamberIn, keyPress, shortCircuit, restoreValid, setTrigType} = 6'h00;
    {setTrigTypeStb, setKvStb, chk, clr} = 4'h0;
    {restoreKv, setKv, expKv} = {7'h00, 7'h00, sgti_pkg::KV_RST};
    cyc(4);
    rst_n = 1'b1;
    cyc(9);
    note(1'b1, {1'b1, sgti_pkg::SGTI_DSP_LAMP, 13'h0}, 17'h1E000);
    cyc(LC - 1);
    note(1'b1, {1'b0, sgti_pkg::SGTI_DSP_CONFIG, autoGunCfg, 12'h0}, 17'h1F000);
    cyc(LC - 1);
    note(1'b1, {1'b0, sgti_pkg::SGTI_DSP_SWREV, 1'b0, 10'h064, 2'h0}, 17'h1EFFC);
    cyc(LC - 1);
    note(1'b1, {1'b0, sgti_pkg::SGTI_DSP_HWREV, 1'b0, 10'h065, 2'h0}, 17'h1EFFC);
    cyc(LC - 1);
    note(1'b1, {1'b0, sgti_pkg::SGTI_DSP_RUN, 13'h0}, 17'h1E000);
    v = 25 + ({$random(seed)} % 76);
    restoreKv = 7'(v);
    expKv = 7'(v);
    restoreValid = 1'b1;
    for (int i = 0; i < 100 && bootDone !== 1'b1; i++) cyc(1);
    restoreValid = 1'b0;
    if (bootDone !== 1'b1) begin
      n_errors++;
      $display("Error at %0t: bootDone %0h expected 1", $time, bootDone);
      stop_test();
    end
    note(1'b0, {9'h000, restoreTrigType, expKv}, 17'h000FF);
    setTrigType = 1'b0;
    pulse(2);
    chamberIn = 1'b1;
    look(10'h000);
    PARENT.run(1'b1);
    look(10'h238);
    PARENT.lock(1'b1);
    look(10'h104);
    PARENT.lock(1'b0);
    chamberIn = 1'b0;
    look(10'h100);
    PARENT.run(1'b0);
    PARENT.lock(1'b1);
    look(10'h004);
    PARENT.lock(1'b0);
    chamberIn = 1'b1;
    PARENT.run(1'b1);
    look(10'h238);
    pulse(0);
    look(10'h102);
    PARENT.toggle();
    look(10'h238);
    chamberIn = 1'b0;
    look(10'h100);
    pulse(0);
    look(10'h102);
    chamberIn = 1'b1;
    look(10'h102);
    PARENT.toggle();
    look(10'h238);
    PARENT.run(1'b0);
    shortCircuit = 1'b1;
    look(10'h080);
    shortCircuit = 1'b0;
    foreach (kvIn[i]) begin
      setKv = kvIn[i];
      expKv = (kvIn[i] == 0) ? 7'h00 : (kvIn[i] < 25) ? 7'h19 : (kvIn[i] > 100) ? 7'h64 : kvIn[i];
      pulse(1);
      look(10'h000);
      note(1'b1, {1'b0, sgti_pkg::SGTI_DSP_RUN, 1'b0, 3'h0, expKv, 2'h0}, 17'h1EFFC);
    end
    setTrigType = 1'b1;
    pulse(2);
    look(10'h239);
    setTrigType = 1'b0;
    pulse(2);
    look(10'h000);
    stop_test();
  end
endmodule : spray_gun_trigger_interlock_tb_top
